// ==== pkg/param_check_pkg.sv ====
// Package with constants and types for the parameter check and error reporter.
// How it works
// (RULE1) Status block: id word at 00H, byte word at 04H, sense from 08H.
// (RULE2) Any failed check writes its code into the status block error byte.
// (RULE3) Catastrophic codes also go out on the status port, unless a request or a self-test result arrives in the same cycle.
// (RULE4) Only defined codes are ever reported; reserved values never leave the block. Here self-test codes pass to the status port unchecked.
// (RULE5) Board-control request (target FFH) with unknown command reports 01H.
// (RULE6) Pass-through with bad tag type, count or address reports 01H.
// (RULE7) Message pass-through with unsupported message reports 01H.
// (RULE8) Target identifier other than 00H-0FH or FFH reports 02H.
// (RULE9) Pass-through aimed at the adapter's own identifier reports 02H.
// (RULE10) Pass-through with embedded LUN above 07H reports 02H.
// (RULE11) General options with override bus identifier above 0FH reports 02H.
// (RULE12) Unit options with unit identifier above 0FH or own identifier reports 02H.
// (RULE13) Self-test results appear on the status port only.
// (RULE14) Several violations give one code by fixed order; the request is not run.
package param_check_pkg;

    // ------------------------------------------------------------
    // Status block layout
    // ------------------------------------------------------------
    localparam logic [7:0] SB_OFS_ID     = 8'h00;
    localparam logic [7:0] SB_OFS_STATUS = 8'h04;
    localparam logic [7:0] SB_OFS_SENSE  = 8'h08;
    localparam int         SB_WORDS      = 4;
    localparam int         SB_ERR_LSB    = 16;
    localparam int         SB_SCSI_LSB   = 8;
    localparam int         SB_FLAG_LSB   = 24;

    // ------------------------------------------------------------
    // Codes and limits
    // ------------------------------------------------------------
    localparam logic [7:0] ERR_NONE        = 8'h00;
    localparam logic [7:0] ERR_INVALID_CMD = 8'h01;
    localparam logic [7:0] ERR_BAD_UNIT    = 8'h02;
    localparam logic [7:0] TID_BOARD       = 8'hFF;
    localparam logic [7:0] TID_MAX         = 8'h0F;
    localparam logic [7:0] LUN_MAX         = 8'h07;
    localparam logic [7:0] CATA_MIN        = 8'h10;

    typedef enum logic [2:0] {
        REQ_BOARD, REQ_PASS, REQ_MSG_PASS, REQ_GEN_OPT, REQ_UNIT_OPT, REQ_XUNIT_OPT
    } req_kind_t;

    typedef struct packed {
        req_kind_t   kind;
        logic [31:0] cmd_id;
        logic [7:0]  target_id;
        logic        cmd_valid;
        logic        tag_valid;
        logic        count_valid;
        logic        addr_valid;
        logic        msg_supported;
        logic [7:0]  lun;
        logic [7:0]  bus_id;
        logic [7:0]  unit_id;
    } req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } port_msg_t;

endpackage

// ==== rtl/status_block_mem.sv ====
// Small memory holding the status block words, with registered read data.
`timescale 1ns/1ps
module status_block_mem #(
    parameter int WORDS = param_check_pkg::SB_WORDS
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     wr_en_in,
    input  wire logic [$clog2(WORDS)-1:0] wr_addr_in,
    input  wire logic [31:0]              wr_data_in,
    input  wire logic [$clog2(WORDS)-1:0] rd_addr_in,
    output logic      [31:0]              rd_data_out
);
    logic [31:0] mem [WORDS];

    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule // status_block_mem

// ==== rtl/param_check_top.sv ====
// Checker of parameter blocks that fills the status block and the status port.
`timescale 1ns/1ps
module param_check_top (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rstn_in,
    input  wire logic                  req_valid_in,
    input  wire param_check_pkg::req_t req_in,
    input  wire logic [7:0]            own_id_in,
    input  wire logic                  fail_valid_in,
    input  wire logic [31:0]           fail_cmd_id_in,
    input  wire logic [7:0]            fail_code_in,
    input  wire logic                  selftest_valid_in,
    input  wire logic [7:0]            selftest_code_in,
    input  wire logic [1:0]            sb_rd_addr_in,
    output logic      [31:0]           sb_rd_data_out,
    output logic                       done_out,
    output logic                       exec_out,
    output logic      [7:0]            err_code_out,
    output param_check_pkg::port_msg_t status_port_out
);
    import param_check_pkg::*;

    // ------------------------------------------------------------
    // Check ordering
    // ------------------------------------------------------------
    function automatic logic [7:0] check(input req_t r, input logic [7:0] own);
        logic [7:0] c;
        c = ERR_NONE;
        if (r.target_id > TID_MAX && r.target_id != TID_BOARD) begin // RULE8
            c = ERR_BAD_UNIT;
        end else if (r.target_id == TID_BOARD) begin
            // The target field, not the kind field, marks a board-control block.
            if (!r.cmd_valid) c = ERR_INVALID_CMD; // RULE5
        end else if (r.kind == REQ_PASS) begin
            if (r.target_id == own) c = ERR_BAD_UNIT; // RULE9
            else if (r.lun > LUN_MAX) c = ERR_BAD_UNIT; // RULE10
            else if (!r.tag_valid || !r.count_valid || !r.addr_valid) c = ERR_INVALID_CMD; // RULE6
        end else if (r.kind == REQ_MSG_PASS) begin
            if (!r.msg_supported) c = ERR_INVALID_CMD; // RULE7
        end else if (r.kind == REQ_GEN_OPT) begin
            if (r.bus_id > TID_MAX) c = ERR_BAD_UNIT; // RULE11
        end else if (r.kind == REQ_UNIT_OPT || r.kind == REQ_XUNIT_OPT) begin
            if (r.unit_id > TID_MAX || r.unit_id == own) c = ERR_BAD_UNIT; // RULE12
        end
        return c;
    endfunction

    // Only 01H, 02H and 10H upward pass; anything else is reserved and dropped.
    function automatic logic legal(input logic [7:0] c);
        return (c == ERR_INVALID_CMD) || (c == ERR_BAD_UNIT) || (c >= CATA_MIN); // RULE4
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic       done;
        logic       exec;
        logic [7:0] code;
        port_msg_t  port;
        logic       wr;
        logic [1:0] wa;
        logic [31:0] wd;
        logic        idwr;
        logic [31:0] cid;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [7:0] chk;

    always_comb begin
        chk = check(req_in, own_id_in);
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.exec = 1'b0;
        st_next.wr = 1'b0;
        st_next.port.valid = 1'b0;
        // The identifier word follows the status word by one cycle on the single write port.
        st_next.idwr = st_reg.wr; // RULE1
        if (selftest_valid_in) begin
            st_next.port.valid = 1'b1; // RULE13
            st_next.port.code = selftest_code_in;
        end
        if (req_valid_in) begin
            // One code per request; a failed request is never executed.
            st_next.done = 1'b1;
            st_next.code = chk;
            st_next.exec = (chk == ERR_NONE); // RULE14
            st_next.cid = req_in.cmd_id;
            st_next.wr = 1'b1;
            st_next.wa = SB_OFS_STATUS[3:2]; // RULE1
            st_next.wd = {24'h000000, chk} << SB_ERR_LSB; // RULE2
        end else if (fail_valid_in && legal(fail_code_in)) begin
            st_next.done = 1'b1;
            st_next.code = fail_code_in;
            st_next.cid = fail_cmd_id_in;
            st_next.wr = 1'b1;
            st_next.wa = SB_OFS_STATUS[3:2]; // RULE1
            st_next.wd = {24'h000000, fail_code_in} << SB_ERR_LSB; // RULE2
            if (fail_code_in >= CATA_MIN && !selftest_valid_in) begin
                st_next.port.valid = 1'b1; // RULE3
                st_next.port.code = fail_code_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    logic        mem_wr;
    logic [1:0]  mem_wa;
    logic [31:0] mem_wd;

    // Status word goes first, the identifier one cycle after it.
    always_comb begin
        mem_wr = st_reg.wr || st_reg.idwr;
        mem_wa = st_reg.wr ? st_reg.wa : SB_OFS_ID[3:2]; // RULE1
        mem_wd = st_reg.wr ? st_reg.wd : st_reg.cid;
    end

    status_block_mem #(.WORDS(SB_WORDS)) status_block_mem_i (
        .clk_sys_in  (clk_sys_in),
        .wr_en_in    (mem_wr),
        .wr_addr_in  (mem_wa),
        .wr_data_in  (mem_wd),
        .rd_addr_in  (sb_rd_addr_in),
        .rd_data_out (sb_rd_data_out)
    );

    assign done_out        = st_reg.done;
    assign exec_out        = st_reg.exec;
    assign err_code_out    = st_reg.code;
    assign status_port_out = st_reg.port;
endmodule // param_check_top

// ==== dv/param_check_props.sv ====
// Checker that watches the ports of the parameter check block.
`timescale 1ns/1ps
module param_check_props (
    input wire logic                       clk_sys_in,
    input wire logic                       rstn_in,
    input wire logic                       req_valid_in,
    input wire param_check_pkg::req_t      req_in,
    input wire logic [7:0]                 own_id_in,
    input wire logic                       fail_valid_in,
    input wire logic [7:0]                 fail_code_in,
    input wire logic                       selftest_valid_in,
    input wire logic [7:0]                 selftest_code_in,
    input wire logic                       done_out,
    input wire logic                       exec_out,
    input wire logic [7:0]                 err_code_out,
    input wire param_check_pkg::port_msg_t status_port_out
);
    import param_check_pkg::*;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    sequence s_req; req_valid_in; endsequence
    sequence s_cata; fail_valid_in && !req_valid_in && fail_code_in >= CATA_MIN && !selftest_valid_in; endsequence
    done_pulse_a: assert property (s_req |=> done_out)
        else $error("No done after a request.");
    bad_target_a: assert property (s_req ##0 (req_in.target_id > TID_MAX && req_in.target_id != TID_BOARD)
        |=> err_code_out == ERR_BAD_UNIT && !exec_out) else $error("Bad target not refused.");
    board_cmd_a: assert property (s_req ##0 (req_in.target_id == TID_BOARD && !req_in.cmd_valid)
        |=> err_code_out == ERR_INVALID_CMD) else $error("Bad board command not refused.");
    own_target_a: assert property (s_req ##0 (req_in.kind == REQ_PASS && req_in.target_id == own_id_in
        && own_id_in <= TID_MAX) |=> err_code_out == ERR_BAD_UNIT) else $error("Own target not refused.");
    defined_code_a: assert property (done_out |-> err_code_out <= ERR_BAD_UNIT || err_code_out >= CATA_MIN)
        else $error("Reserved code reported.");
    cata_port_a: assert property (s_cata |=> status_port_out.valid
        && status_port_out.code == $past(fail_code_in)) else $error("Catastrophic code not on port.");
    selftest_port_a: assert property (selftest_valid_in && !req_valid_in && !fail_valid_in
        |=> status_port_out.valid && !done_out
        && status_port_out.code == $past(selftest_code_in)) else $error("Self-test code not on port.");
    exec_clean_a: assert property (exec_out |-> done_out && err_code_out == ERR_NONE)
        else $error("Execution with an error code.");
endmodule // param_check_props
bind param_check_top param_check_props param_check_props_i (.*);

// ==== dv/host_model.sv ====
// Host side model that hands parameter blocks to the block.
`timescale 1ns/1ps
module host_model (
    input  wire logic                  clk_sys_in,
    output logic                       req_valid_out,
    output param_check_pkg::req_t      req_out
);
    import param_check_pkg::*;
    initial begin
        req_valid_out = 1'b0;
        req_out       = '0;
    end
    // One block per call; valid stands for exactly one edge.
    task automatic issue(input req_t r);
        @(posedge clk_sys_in);
        req_valid_out <= 1'b1;
        req_out       <= r;
        @(posedge clk_sys_in);
        req_valid_out <= 1'b0;
    endtask
endmodule // host_model

// ==== dv/param_check_top_tb.sv ====
// Self-checking bench for the parameter check block.
`timescale 1ns/1ps
module param_check_top_tb;
    import param_check_pkg::*;
    logic clk_sys_in = 1'b0, rstn_in = 1'b0, fv = 1'b0, sv = 1'b0, done, exec, hv;
    logic [7:0] own = 8'h07, fc = 8'h00, sc = 8'h00, err, o, e;
    logic [31:0] fid = 32'h0, rdata;
    logic [1:0] rd = 2'h0;
    req_t r, hreq;
    port_msg_t port;
    int mismatches = 0, compares = 0, t;
    logic [7:0] fcodes[9] = '{8'h01, 8'h02, 8'h10, 8'h11, 8'h14, 8'h15, 8'h1D, 8'h1E, 8'h03};
    always #5 clk_sys_in = ~clk_sys_in;
    host_model host_model_i (.clk_sys_in(clk_sys_in), .req_valid_out(hv), .req_out(hreq));
    param_check_top param_check_top_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .req_valid_in(hv),
        .req_in(hreq), .own_id_in(own), .fail_valid_in(fv), .fail_cmd_id_in(fid), .fail_code_in(fc),
        .selftest_valid_in(sv), .selftest_code_in(sc), .sb_rd_addr_in(rd), .sb_rd_data_out(rdata),
        .done_out(done), .exec_out(exec), .err_code_out(err), .status_port_out(port));
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        compares++;
        if (g !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    // ----------------------------------------
    // Reference model in fixed check order
    // ----------------------------------------
    function automatic logic [7:0] model(req_t q, logic [7:0] w);
        if (q.target_id > 8'h0F && q.target_id != 8'hFF) return 8'h02;
        if (q.target_id == 8'hFF) return q.cmd_valid ? 8'h00 : 8'h01;
        case (q.kind)
            REQ_PASS: begin
                if (q.target_id == w || q.lun > 8'h07) return 8'h02;
                return (q.tag_valid && q.count_valid && q.addr_valid) ? 8'h00 : 8'h01;
            end
            REQ_MSG_PASS: return q.msg_supported ? 8'h00 : 8'h01;
            REQ_GEN_OPT: return q.bus_id > 8'h0F ? 8'h02 : 8'h00;
            REQ_UNIT_OPT, REQ_XUNIT_OPT: return (q.unit_id > 8'h0F || q.unit_id == w) ? 8'h02 : 8'h00;
            default: return 8'h00;
        endcase
    endfunction
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        print_verdict;
    end
    initial begin
        void'($urandom(46607));
        repeat (3) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 300; i++) begin
            t = $urandom % 8;
            o = 8'($urandom % 16);
            r = req_t'(72'({$urandom, $urandom, $urandom}));
            r.kind = req_kind_t'($urandom % 6);
            r.target_id = t == 0 ? 8'hFF : t == 1 ? 8'($urandom) : t == 2 ? o : 8'($urandom % 16);
            {r.cmd_valid, r.tag_valid, r.count_valid, r.addr_valid, r.msg_supported} = ~5'(1 << ($urandom % 8));
            r.lun = 8'($urandom % 10);
            r.bus_id = 8'($urandom % 20);
            r.unit_id = t == 3 ? o : 8'($urandom % 20);
            e = model(r, o);
            @(posedge clk_sys_in);
            own <= o;
            host_model_i.issue(r);
            @(negedge clk_sys_in);
            chk("done", 32'h1, 32'(done));
            chk("code", 32'(e), 32'(err));
            chk("exec", 32'(e == 8'h00), 32'(exec));
            repeat (2) @(posedge clk_sys_in);
            rd <= 2'h1;
            @(posedge clk_sys_in);
            rd <= 2'h0;
            @(negedge clk_sys_in);
            chk("status word", {8'h00, e, 16'h0000}, rdata);
            @(negedge clk_sys_in);
            chk("id word", r.cmd_id, rdata);
        end
        $display("Test random requests done.");
        foreach (fcodes[k]) begin
            @(posedge clk_sys_in);
            fv <= 1'b1;
            fc <= fcodes[k];
            fid <= $urandom;
            @(posedge clk_sys_in);
            fv <= 1'b0;
            @(negedge clk_sys_in);
            chk("fail done", 32'(fcodes[k] != 8'h03), 32'(done));
            chk("fail port valid", 32'(fcodes[k] >= 8'h10), 32'(port.valid));
            if (fcodes[k] >= 8'h10) chk("fail port code", 32'(fcodes[k]), 32'(port.code));
            if (fcodes[k] != 8'h03) chk("fail code", 32'(fcodes[k]), 32'(err));
        end
        $display("Test failure codes done.");
        @(posedge clk_sys_in);
        sv <= 1'b1;
        sc <= 8'h5A;
        @(posedge clk_sys_in);
        sv <= 1'b0;
        @(negedge clk_sys_in);
        chk("selftest port", {23'h0, 1'b1, 8'h5A}, 32'(port));
        chk("selftest done", 32'h0, 32'(done));
        $display("Test self-test done.");
        print_verdict;
    end
endmodule // param_check_top_tb
